// ===== design/efzs_pkg.sv
// constants, codes and types shared by the field edit / zero suppress datapath
`default_nettype none
package efzs_pkg;
	// ****************************************
	// widths
	// ****************************************
	localparam int CHAR_W = 6;
	localparam int FIELD_CHARS = 16;
	localparam int ACC_W = CHAR_W * FIELD_CHARS;
	localparam int ADDR_W = 15;
	localparam int LEN_W = 5;
	localparam int CNT_W = 16;
	// ****************************************
	// character codes
	// ****************************************
	localparam logic [5:0] CH_DATA_SLOT = 6'h20;
	localparam logic [5:0] CH_MINUS = 6'h02;
	localparam logic [5:0] CH_ZONE_STRIP = 6'h3F;
	localparam logic [5:0] ZONE_CLEAR = 6'h0F;
	localparam logic [5:0] CH_BLANK = 6'h05;
	localparam logic [5:0] CH_ZERO = 6'h10;
	localparam logic [5:0] CH_COMMA = 6'h3B;
	localparam logic [5:0] CH_STAR = 6'h2B;
	localparam logic [5:0] CH_DOLLAR = 6'h2C;
	// ****************************************
	// tally location
	// ****************************************
	localparam int TALLY_TETRAD = 18;
	localparam int TALLY_CHAR_POS = 1;
	// ****************************************
	// edit timing, in tenths of a time unit
	// ****************************************
	localparam int EDIT_BASE_TENTHS = 360;
	localparam int EDIT_PER_CHAR_TENTHS = 135;
	localparam int EDIT_PER_INS_TENTHS = 90;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TIME_UNIT_NS = 80;
	localparam int CYC_PER_TENTH_RAW = (TIME_UNIT_NS + 10 * CLK_PERIOD_NS - 1) / (10 * CLK_PERIOD_NS);
	localparam int CYC_PER_TENTH = (CYC_PER_TENTH_RAW < 1) ? 1 : CYC_PER_TENTH_RAW;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		picture_format_op = 2'b00,
		lead_blank_fill_op = 2'b01,
		lead_currency_fill_op = 2'b10,
		lead_star_fill_op = 2'b11
	} efzs_op_t;
	typedef enum logic [2:0] {
		efzs_idle = 3'b000,
		efzs_edit = 3'b001,
		efzs_zs_rd = 3'b010,
		efzs_zs_wait = 3'b011,
		efzs_zs_chk = 3'b100,
		efzs_tally = 3'b101,
		efzs_hold = 3'b110
	} efzs_state_t;
endpackage : efzs_pkg
`default_nettype wire

// ===== design/efzs_edit_map.sv
// combinational merge of data field and picture mask
`default_nettype none
module efzs_edit_map (
	input wire logic [efzs_pkg::ACC_W-1:0] mask,
	input wire logic [efzs_pkg::ACC_W-1:0] data,
	input wire logic negative,
	input wire logic [efzs_pkg::LEN_W-1:0] len,
	output logic [efzs_pkg::ACC_W-1:0] out_chars,
	output logic [efzs_pkg::LEN_W-1:0] span,
	output logic [efzs_pkg::LEN_W-1:0] inserted
);
	import efzs_pkg::*;
	logic [LEN_W-1:0] used;
	logic [CHAR_W-1:0] c;
	always_comb begin
		out_chars = '0;
		span = '0;
		c = '0;
		used = (mask[CHAR_W-1:0] == CH_ZONE_STRIP) ? 5'h01 : 5'h00;
		for (int i = 0; i < FIELD_CHARS; i++) begin
			c = mask[i*CHAR_W +: CHAR_W];
			if (i == 0 && c == CH_ZONE_STRIP) begin
				out_chars[CHAR_W-1:0] = data[CHAR_W-1:0] & ZONE_CLEAR;
			end else if (i == 0 && c == CH_MINUS) begin
				out_chars[CHAR_W-1:0] = negative ? CH_MINUS : CH_BLANK;
			end else if (c == CH_DATA_SLOT && used < len) begin
				out_chars[i*CHAR_W +: CHAR_W] = data[used[3:0]*CHAR_W +: CHAR_W];
				used = 5'(used + 5'h01);
			end else begin
				out_chars[i*CHAR_W +: CHAR_W] = c;
			end
			if (span == 5'h00 && used >= len) begin
				span = 5'(i + 1);
			end
		end
		// a short mask is the program's fault; write the whole picture
		if (span == 5'h00) begin
			span = 5'h10;
		end
		inserted = 5'(span - len);
	end
endmodule : efzs_edit_map
`default_nettype wire

// ===== design/efzs_core.sv
// field edit and zero suppress sequencer with storage and tally ports
// ****************************************
// Overview of operation
// - edit length comes from length operand; result written from effective address
// - each data-slot mask character takes the next data character
// - minus code in lowest mask position gives blank or minus by sign
// - zone-strip code in lowest mask position copies lowest data character with zone bits cleared
// - edit leaves the mask in the second accumulator unchanged
// - edit time is 36 plus 13.5 per character plus 9 per insertion
// - blank variant blanks leading fill characters; star variant writes asterisks
// - currency variant blanks, then puts dollar left of first kept character
// - scan left to right from address, up to length, stop at non-fill
// - suppressed count 0 to 16 goes to second character of tetrad 18
// - zero suppress leaves both accumulators unchanged
// ****************************************
`default_nettype none
module efzs_core (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire efzs_pkg::efzs_op_t op,
	input wire logic [efzs_pkg::LEN_W-1:0] field_len,
	input wire logic [efzs_pkg::ADDR_W-1:0] eff_addr,
	input wire logic [efzs_pkg::ACC_W-1:0] first_accumulator,
	input wire logic first_accumulator_negative,
	input wire logic [efzs_pkg::ACC_W-1:0] second_accumulator,
	input wire logic [efzs_pkg::CHAR_W-1:0] mem_rdata,
	output logic [efzs_pkg::ADDR_W-1:0] mem_addr,
	output logic mem_re,
	output logic mem_we,
	output logic [efzs_pkg::CHAR_W-1:0] mem_wdata,
	output logic tally_we,
	output logic [efzs_pkg::CHAR_W-1:0] suppress_tally,
	output logic busy,
	output logic done
);
	import efzs_pkg::*;
	// ****************************************
	// state
	// ****************************************
	efzs_state_t state, next_state;
	efzs_op_t op_q, next_op_q;
	logic [ADDR_W-1:0] base_q, next_base_q;
	logic [LEN_W-1:0] len_q, next_len_q, idx, next_idx, span_q, next_span_q;
	logic [ACC_W-1:0] edit_q, next_edit_q;
	logic [CNT_W-1:0] cnt_q, next_cnt_q, target_q, next_target_q;
	logic [ADDR_W-1:0] next_mem_addr;
	logic next_mem_re, next_mem_we, next_tally_we, next_busy, next_done;
	logic [CHAR_W-1:0] next_mem_wdata, next_suppress_tally;
	logic last_q, next_last_q, neg_q, next_neg_q;
	logic [CHAR_W-1:0] mask0_q, next_mask0_q;
	logic [ACC_W-1:0] map_out;
	logic [LEN_W-1:0] map_span, map_ins, pos;
	logic fill_char;
	// accumulators are only read, never written back
	efzs_edit_map u_map (
		.mask(second_accumulator),
		.data(first_accumulator),
		.negative(first_accumulator_negative),
		.len(field_len),
		.out_chars(map_out),
		.span(map_span),
		.inserted(map_ins)
	);
	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		next_state = state;
		next_op_q = op_q;
		next_base_q = base_q;
		next_len_q = len_q;
		next_idx = idx;
		next_span_q = span_q;
		next_edit_q = edit_q;
		next_target_q = target_q;
		next_cnt_q = (state == efzs_idle) ? '0 : CNT_W'(cnt_q + 16'h0001);
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_re = 1'b0;
		next_mem_we = 1'b0;
		next_tally_we = 1'b0;
		next_suppress_tally = suppress_tally;
		next_busy = busy;
		next_done = 1'b0;
		next_last_q = 1'b0;
		next_neg_q = neg_q;
		next_mask0_q = mask0_q;
		pos = 5'(span_q - 5'h01 - idx);
		fill_char = (mem_rdata == CH_BLANK) || (mem_rdata == CH_ZERO) || (mem_rdata == CH_COMMA);
		case (state)
			efzs_idle: begin
				if (start) begin
					next_op_q = op;
					next_base_q = eff_addr;
					next_len_q = field_len;
					next_idx = '0;
					next_busy = 1'b1;
					if (op == picture_format_op) begin
						next_edit_q = map_out;
						next_span_q = map_span;
						next_neg_q = first_accumulator_negative;
						next_mask0_q = second_accumulator[CHAR_W-1:0];
						next_target_q = CNT_W'((EDIT_BASE_TENTHS + EDIT_PER_CHAR_TENTHS * int'(field_len)
							+ EDIT_PER_INS_TENTHS * int'(map_ins)) * CYC_PER_TENTH);
						next_state = efzs_edit;
					end else begin
						next_state = efzs_zs_rd;
					end
				end
			end
			efzs_edit: begin
				next_mem_we = 1'b1;
				next_mem_addr = ADDR_W'(base_q + 15'(idx));
				next_mem_wdata = edit_q[pos[3:0]*CHAR_W +: CHAR_W];
				next_last_q = (pos == 5'h00);
				next_idx = 5'(idx + 5'h01);
				if (pos == 5'h00) begin
					next_state = efzs_hold;
				end
			end
			efzs_hold: begin
				// completion waits out the full instruction time
				if (cnt_q >= target_q) begin
					next_done = 1'b1;
					next_busy = 1'b0;
					next_state = efzs_idle;
				end
			end
			efzs_zs_rd: begin
				next_mem_re = 1'b1;
				next_mem_addr = ADDR_W'(base_q + 15'(idx));
				next_state = efzs_zs_wait;
			end
			efzs_zs_wait: begin
				next_state = efzs_zs_chk;
			end
			efzs_zs_chk: begin
				if (fill_char) begin
					next_mem_we = 1'b1;
					next_mem_addr = ADDR_W'(base_q + 15'(idx));
					next_mem_wdata = (op_q == lead_star_fill_op) ? CH_STAR : CH_BLANK;
					next_idx = 5'(idx + 5'h01);
					// whole field suppressed: no dollar written
					next_state = (5'(idx + 5'h01) == len_q) ? efzs_tally : efzs_zs_rd;
				end else begin
					// a zero count puts the dollar just before the field
					if (op_q == lead_currency_fill_op) begin
						next_mem_we = 1'b1;
						next_mem_addr = ADDR_W'(base_q + 15'(idx) - 15'h0001);
						next_mem_wdata = CH_DOLLAR;
					end
					next_state = efzs_tally;
				end
			end
			efzs_tally: begin
				next_tally_we = 1'b1;
				next_suppress_tally = 6'(idx);
				next_done = 1'b1;
				next_busy = 1'b0;
				next_state = efzs_idle;
			end
			default: begin
				next_state = efzs_idle;
				next_busy = 1'b0;
			end
		endcase
	end
	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= efzs_idle;
			op_q <= picture_format_op;
			base_q <= '0;
			len_q <= '0;
			idx <= '0;
			span_q <= '0;
			edit_q <= '0;
			cnt_q <= '0;
			target_q <= '0;
			mem_addr <= '0;
			mem_re <= 1'b0;
			mem_we <= 1'b0;
			mem_wdata <= '0;
			tally_we <= 1'b0;
			suppress_tally <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			last_q <= 1'b0;
			neg_q <= 1'b0;
			mask0_q <= '0;
		end else begin
			state <= next_state;
			op_q <= next_op_q;
			base_q <= next_base_q;
			len_q <= next_len_q;
			idx <= next_idx;
			span_q <= next_span_q;
			edit_q <= next_edit_q;
			cnt_q <= next_cnt_q;
			target_q <= next_target_q;
			mem_addr <= next_mem_addr;
			mem_re <= next_mem_re;
			mem_we <= next_mem_we;
			mem_wdata <= next_mem_wdata;
			tally_we <= next_tally_we;
			suppress_tally <= next_suppress_tally;
			busy <= next_busy;
			done <= next_done;
			last_q <= next_last_q;
			neg_q <= next_neg_q;
			mask0_q <= next_mask0_q;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	property p_edit_first_write;
		@(posedge clock) disable iff (rst)
		(state == efzs_idle && start && op == picture_format_op)
			|-> ##2 (mem_we && mem_addr == $past(eff_addr, 2));
	endproperty
	a_edit_first_write: assert property (p_edit_first_write) else $error("edit start address");
	property p_edit_sign;
		@(posedge clock) disable iff (rst)
		(mem_we && op_q == picture_format_op && last_q && mask0_q == CH_MINUS)
			|-> (mem_wdata == (neg_q ? CH_MINUS : CH_BLANK));
	endproperty
	a_edit_sign: assert property (p_edit_sign) else $error("edit sign position wrong");
	property p_edit_zone;
		@(posedge clock) disable iff (rst)
		(mem_we && op_q == picture_format_op && last_q && mask0_q == CH_ZONE_STRIP)
			|-> ((mem_wdata & ~ZONE_CLEAR) == 6'h00);
	endproperty
	a_edit_zone: assert property (p_edit_zone) else $error("zone bits not stripped");
	property p_edit_time;
		@(posedge clock) disable iff (rst)
		(done && op_q == picture_format_op) |-> ($past(cnt_q) == $past(target_q));
	endproperty
	a_edit_time: assert property (p_edit_time) else $error("edit time mismatch");
	property p_star_fill;
		@(posedge clock) disable iff (rst)
		(mem_we && op_q == lead_star_fill_op) |-> (mem_wdata == CH_STAR);
	endproperty
	a_star_fill: assert property (p_star_fill) else $error("star fill wrong");
	property p_dollar_place;
		@(posedge clock) disable iff (rst)
		(mem_we && op_q == lead_currency_fill_op && mem_wdata == CH_DOLLAR)
			|-> ##1 (tally_we && suppress_tally == 6'($past(mem_addr) - $past(base_q) + 15'h0001));
	endproperty
	a_dollar_place: assert property (p_dollar_place) else $error("dollar misplaced");
	property p_scan_range;
		@(posedge clock) disable iff (rst)
		mem_re |-> (15'(mem_addr - base_q) < 15'(len_q));
	endproperty
	a_scan_range: assert property (p_scan_range) else $error("scan past field");
	property p_tally_bound;
		@(posedge clock) disable iff (rst)
		tally_we |-> (suppress_tally <= 6'(len_q) && done && !busy);
	endproperty
	a_tally_bound: assert property (p_tally_bound) else $error("tally out of range");
	property p_full_no_dollar;
		@(posedge clock) disable iff (rst)
		(tally_we && suppress_tally == 6'(len_q)) |-> !($past(mem_we) && $past(mem_wdata) == CH_DOLLAR);
	endproperty
	a_full_no_dollar: assert property (p_full_no_dollar) else $error("dollar on full field");
	c_edit_done: cover property (@(posedge clock) disable iff (rst) done && op_q == picture_format_op);
	c_tally_zero: cover property (@(posedge clock) disable iff (rst) tally_we && suppress_tally == 6'h00);
	c_tally_full: cover property (@(posedge clock) disable iff (rst) tally_we && suppress_tally == 6'h10);
	c_dollar: cover property (@(posedge clock) disable iff (rst) mem_we && mem_wdata == CH_DOLLAR);
endmodule : efzs_core
`default_nettype wire

// ===== test/efzs_tb.sv
// self-checking bench for the field edit and zero suppress datapath
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import efzs_pkg::*;
	// ****************************************
	// stimulus and storage model
	// ****************************************
	logic clock;
	logic rst;
	logic start;
	efzs_op_t op;
	logic [LEN_W-1:0] field_len;
	logic [ADDR_W-1:0] eff_addr;
	logic [ACC_W-1:0] first_accumulator;
	logic first_accumulator_negative;
	logic [ACC_W-1:0] second_accumulator;
	logic [CHAR_W-1:0] mem_rdata;
	logic [ADDR_W-1:0] mem_addr;
	logic mem_re;
	logic mem_we;
	logic [CHAR_W-1:0] mem_wdata;
	logic tally_we;
	logic [CHAR_W-1:0] suppress_tally;
	logic busy;
	logic done;
	logic [5:0] mem [0:63];
	int err_total = 0;
	int checks_done = 0;
	int cycle_count = 0;
	efzs_core uut (.clock(clock), .rst(rst), .start(start), .op(op), .field_len(field_len),
		.eff_addr(eff_addr), .first_accumulator(first_accumulator),
		.first_accumulator_negative(first_accumulator_negative),
		.second_accumulator(second_accumulator), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
		.mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata), .tally_we(tally_we),
		.suppress_tally(suppress_tally), .busy(busy), .done(done));
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	// read data only valid the cycle after a strobe; otherwise it keeps toggling
	always @(posedge clock) begin
		if (mem_we) mem[mem_addr[5:0]] <= mem_wdata;
		if (mem_re) mem_rdata <= #1 mem[mem_addr[5:0]];
		else mem_rdata <= #1 ~mem_rdata;
		cycle_count++;
		if (cycle_count >= 10000) begin
			err_total++;
			test_done();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic test_done();
		if (err_total == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic chk_mem(input string name, input int idx, input logic [5:0] exp);
		check(name, 16'(mem[idx]), 16'(exp));
	endtask : chk_mem
	// starts in the done cycle of the previous run, so back-to-back is exercised
	task automatic run_op(input efzs_op_t o, input int l, input int a, output int cyc);
		op = o;
		field_len = LEN_W'(l);
		eff_addr = ADDR_W'(a);
		start = 1;
		@(posedge clock);
		#1 start = 0;
		cyc = 1;
		while (done !== 1'b1 && cyc < 5000) begin
			@(posedge clock);
			#1 cyc++;
		end
	endtask : run_op
	// ****************************************
	// scenarios
	// ****************************************
	task automatic edit_sign();
		int cyc;
		second_accumulator = '0;
		second_accumulator[23:0] = {CH_DATA_SLOT, 6'h1B, CH_DATA_SLOT, CH_MINUS};
		first_accumulator = '0;
		first_accumulator[11:0] = {6'h32, 6'h34};
		for (int n = 0; n < 2; n++) begin
			first_accumulator_negative = n[0];
			mem[12] = 6'h3E;
			run_op(picture_format_op, 2, 8, cyc);
			check("edit_cycles", 16'(cyc), 16'h032C);
			chk_mem("edit_hi", 8, 6'h32);
			chk_mem("edit_ins", 9, 6'h1B);
			chk_mem("edit_lo", 10, 6'h34);
			chk_mem("edit_sign", 11, n ? CH_MINUS : CH_BLANK);
			chk_mem("edit_past", 12, 6'h3E);
		end
	endtask : edit_sign
	task automatic edit_strip();
		int cyc;
		second_accumulator = '0;
		second_accumulator[11:0] = {CH_DATA_SLOT, CH_ZONE_STRIP};
		first_accumulator[11:0] = {6'h27, 6'h34};
		mem[18] = 6'h3E;
		run_op(picture_format_op, 2, 16, cyc);
		check("strip_cycles", 16'(cyc), 16'h0278);
		chk_mem("strip_hi", 16, 6'h27);
		chk_mem("strip_lo", 17, 6'h34 & ZONE_CLEAR);
		chk_mem("strip_past", 18, 6'h3E);
	endtask : edit_strip
	task automatic zs_lead();
		efzs_op_t ops [3] = '{lead_blank_fill_op, lead_star_fill_op, lead_currency_fill_op};
		int cyc;
		logic [5:0] fill;
		for (int i = 0; i < 3; i++) begin
			{mem[31], mem[32], mem[33], mem[34]} = {6'h3E, CH_ZERO, CH_COMMA, CH_BLANK};
			{mem[35], mem[36]} = {6'h33, CH_ZERO};
			run_op(ops[i], 5, 32, cyc);
			check("zs_cycles", 16'(cyc), 16'h000E);
			check("zs_tally_we", 16'(tally_we), 16'h0001);
			check("zs_tally", 16'(suppress_tally), 16'h0003);
			fill = (i == 1) ? CH_STAR : CH_BLANK;
			chk_mem("zs_c0", 32, fill);
			chk_mem("zs_c1", 33, fill);
			chk_mem("zs_c2", 34, (i == 2) ? CH_DOLLAR : fill);
			chk_mem("zs_kept", 35, 6'h33);
			chk_mem("zs_after", 36, CH_ZERO);
			chk_mem("zs_before", 31, 6'h3E);
		end
	endtask : zs_lead
	task automatic zs_all();
		int cyc;
		mem[39] = 6'h3E;
		for (int k = 40; k < 44; k++) mem[k] = CH_ZERO;
		run_op(lead_currency_fill_op, 4, 40, cyc);
		check("all_cycles", 16'(cyc), 16'h000E);
		check("all_tally", 16'(suppress_tally), 16'h0004);
		for (int k = 40; k < 44; k++) chk_mem("all_fill", k, CH_BLANK);
		chk_mem("all_no_dollar", 39, 6'h3E);
	endtask : zs_all
	task automatic zs_none();
		int cyc;
		{mem[47], mem[48], mem[49]} = {6'h3E, 6'h33, CH_ZERO};
		run_op(lead_currency_fill_op, 3, 48, cyc);
		check("none_cycles", 16'(cyc), 16'h0005);
		check("none_tally", 16'(suppress_tally), 16'h0000);
		chk_mem("none_dollar", 47, CH_DOLLAR);
		chk_mem("none_kept", 48, 6'h33);
		chk_mem("none_after", 49, CH_ZERO);
	endtask : zs_none
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1;
		start = 0;
		op = picture_format_op;
		field_len = '0;
		eff_addr = '0;
		first_accumulator = '0;
		first_accumulator_negative = 0;
		second_accumulator = '0;
		mem_rdata = '0;
		for (int k = 0; k < 64; k++) mem[k] = 6'h00;
		repeat (10) @(posedge clock);
		#1 rst = 0;
		check("idle_busy", 16'(busy), 16'h0000);
		edit_sign();
		edit_strip();
		zs_lead();
		zs_all();
		zs_none();
		test_done();
	end
endmodule : tb
`default_nettype wire
